// File: src/watchdog_power_supervisor.sv
// watchdog timer, oscillator supervisor and power saving mode control
//
// Behaviour
// - watchdog is a 15-bit up-counter ticking at clock/6 or clock/192.
// - software sets only the upper 7 counter bits, through the reload value.
// - start bit or hardware start pin starts it; only reset stops it when active.
// - overflow of the running counter without refresh raises internal reset.
// - valid refresh loads the reload value into the upper 7 counter bits.
// - refresh is refresh-bit write followed directly by start-bit write only.
// - a readable flag tells watchdog reset from external reset.
// - counter holds in idle and power-down.
// - main oscillator slower than RC: switch to RC clock, hold reset.
// - main faster again: keep reset for 1 ms, then release.
// - after power-on the same monitoring sequence gates reset release.
// - leaving hardware power-down runs the same oscillator check.
// - software power-down stops both oscillators, restarts them on release.
// - after wake-up and 1 ms settling, resume with wake interrupt at 007b.
// - idle entry is bit 01h then bit 20h; CPU clock stops; irq or reset exits.
// - power-down entry is bit 02h then 40h; exit by reset or irq0 low pulse.
// - hardware power-down pin low holds reset, oscillator stopped, ports float.
// - bit 10h divides all clocks by 32; clearing it or reset restores.
// - interrupt exit keeps state; reset exit replaces it with reset state.
//
// Our own choices: the placing of the registers and strobed register access.
module watchdog_power_supervisor
  import wdps_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // pins and events
  input wire logic main_osc_slow_i,
  input wire logic hw_powerdown_pin_i,
  input wire logic ext_irq0_wake_pin_i,
  input wire logic wdt_hw_start_pin_i,
  input wire logic periph_irq_i,
  // clock and reset control
  output logic sys_rst_o,
  output logic clk_sel_rc_o,
  output logic osc_stop_o,
  output logic rc_osc_stop_o,
  output logic ports_float_o,
  output logic cpu_clk_stop_o,
  output logic clk_div32_o,
  output logic wake_irq_o,
  output logic [15:0] wake_vector_o
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] filt;
    osc_state_t osc;
    logic [SETTLE_W-1:0] settle_cnt;
    logic waking;
    logic [7:0] pwr;
    logic arm_idle;
    logic arm_pd;
    logic arm_ref;
    logic idle;
    logic swpd;
    logic run;
    logic rate;
    logic cause;
    logic [WDT_W-1:0] cnt;
    logic [RELOAD_W-1:0] reload;
    logic [7:0] pre;
    logic [4:0] div32;
    logic [7:0] rdata;
    logic sys_rst;
    logic rc_sel;
    logic osc_stop;
    logic rc_stop;
    logic ports_float;
    logic cpu_stop;
    logic wake_irq;
    logic [15:0] vec;
  } state_t;

  state_t q;
  state_t d;

  logic wr_pwr;
  logic wr_wd;
  logic wr_rel;
  logic idle_go;
  logic pd_go;
  logic refresh;
  logic tick;
  logic ovf;
  logic slow_ok;
  logic hwoff_low;
  logic [7:0] pre_last;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    hit = (a == target);
  endfunction

  always_comb begin
    d = q;
    d.wake_irq = 1'b0;
    // three-stage pin synchronisers; a level counts once stages two and three agree
    d.s1 = {wdt_hw_start_pin_i, ext_irq0_wake_pin_i, hw_powerdown_pin_i, main_osc_slow_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 4; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.filt[i] = q.s3[i];
      end
    end
    slow_ok = !q.filt[SY_SLOW];
    hwoff_low = !q.filt[SY_HWOFF];

    // register write decode
    wr_pwr = 1'b0;
    wr_wd = 1'b0;
    wr_rel = 1'b0;
    if (reg_wr_i && hit(reg_addr_i, ADDR_PWR)) begin
      wr_pwr = 1'b1;
    end else if (reg_wr_i && hit(reg_addr_i, ADDR_WDCTL)) begin
      wr_wd = 1'b1;
    end else if (reg_wr_i && hit(reg_addr_i, ADDR_RELOAD)) begin
      wr_rel = 1'b1;
    end

    // two-step sequences: any other write in between disarms
    idle_go = wr_pwr && reg_wdata_i[PC_IDLE2] && q.arm_idle;
    pd_go = wr_pwr && reg_wdata_i[PC_PD2] && q.arm_pd;
    refresh = wr_wd && reg_wdata_i[WC_START] && q.arm_ref;
    if (reg_wr_i) begin
      d.arm_idle = wr_pwr && reg_wdata_i[PC_IDLE1];
      d.arm_pd = wr_pwr && reg_wdata_i[PC_PD1];
      d.arm_ref = wr_wd && reg_wdata_i[WC_REFRESH];
    end
    if (wr_pwr) begin
      d.pwr = reg_wdata_i & PWR_MASK;
    end
    if (wr_rel) begin
      d.reload = reg_wdata_i[RELOAD_W-1:0];
    end
    if (wr_wd) begin
      d.rate = reg_wdata_i[WC_RATE];
    end

    // watchdog prescaler, further divided by 32 in slow-down
    d.div32 = q.div32 + 5'h01;
    pre_last = q.rate ? PRE_SLOW_LAST : PRE_FAST_LAST;
    tick = 1'b0;
    if (q.run && !q.idle && !q.swpd && (!q.pwr[PC_SLOW] || q.div32 == SLOWDOWN_LAST)) begin
      if (q.pre == pre_last) begin
        d.pre = 8'h00;
        tick = 1'b1;
      end else begin
        d.pre = q.pre + 8'h01;
      end
    end
    ovf = tick && (q.cnt == WDT_MAX);
    if (tick) begin
      d.cnt = q.cnt + 15'h0001;
    end
    if ((wr_wd && reg_wdata_i[WC_START]) || q.filt[SY_HWST]) begin
      d.run = 1'b1;
    end
    if (refresh) begin
      d.cnt = {q.reload, 8'h00};
    end
    if (ovf) begin
      d.cause = 1'b1;
    end

    // idle mode
    if (idle_go) begin
      d.idle = 1'b1;
    end
    if (q.idle && periph_irq_i) begin
      d.idle = 1'b0;
      d.pwr[PC_IDLE1] = 1'b0;
      d.pwr[PC_IDLE2] = 1'b0;
    end
    if (pd_go) begin
      d.swpd = 1'b1;
    end

    // oscillator supervisor
    case (q.osc)
      OSC_FAIL: begin
        if (slow_ok) begin
          d.osc = OSC_SETTLE;
          d.settle_cnt = '0;
        end
      end
      OSC_SETTLE: begin
        if (!slow_ok) begin
          d.osc = OSC_FAIL;
        end else if (q.settle_cnt == SETTLE_W'(SETTLE_CYCLES - 1)) begin
          d.osc = OSC_RUN;
          if (q.waking) begin
            d.waking = 1'b0;
            d.wake_irq = 1'b1;
            d.swpd = 1'b0;
            d.pwr[PC_PD1] = 1'b0;
            d.pwr[PC_PD2] = 1'b0;
          end
        end else begin
          d.settle_cnt = q.settle_cnt + 20'h00001;
        end
      end
      OSC_RUN: begin
        if (!slow_ok) begin
          d.osc = OSC_FAIL;
        end else if (q.swpd) begin
          d.osc = OSC_SWPD;
        end
      end
      OSC_SWPD: begin
        if (!q.filt[SY_INT0]) begin
          d.osc = OSC_FAIL;
          d.waking = 1'b1;
        end
      end
      OSC_HWOFF: begin
        if (!hwoff_low) begin
          d.osc = OSC_FAIL;
        end
      end
      default: begin
        d.osc = OSC_FAIL;
      end
    endcase
    if (hwoff_low) begin
      d.osc = OSC_HWOFF;
      d.waking = 1'b0;
    end

    // internal reset returns the device state to its reset values, except the watchdog cause flag
    if (q.sys_rst) begin
      d.pwr = PWR_RST;
      d.arm_idle = 1'b0;
      d.arm_pd = 1'b0;
      d.arm_ref = 1'b0;
      d.idle = 1'b0;
      d.swpd = 1'b0;
      d.run = 1'b0;
      d.rate = 1'b0;
      d.cnt = '0;
      d.reload = '0;
      d.pre = 8'h00;
    end

    // registered outputs
    d.sys_rst = ovf || (d.osc == OSC_HWOFF) || (((d.osc == OSC_FAIL) || (d.osc == OSC_SETTLE)) && !d.waking);
    d.rc_sel = (d.osc == OSC_FAIL);
    d.osc_stop = (d.osc == OSC_HWOFF) || (d.osc == OSC_SWPD);
    d.rc_stop = (d.osc == OSC_SWPD);
    d.ports_float = (d.osc == OSC_HWOFF);
    d.cpu_stop = d.idle || d.swpd || d.waking;

    // register read, data in the following cycle
    d.rdata = 8'h00;
    if (reg_rd_i && hit(reg_addr_i, ADDR_PWR)) begin
      d.rdata = q.pwr;
    end else if (reg_rd_i && hit(reg_addr_i, ADDR_WDCTL)) begin
      d.rdata = {3'h0, q.rate, q.run, q.cause, q.run, 1'b0};
    end else if (reg_rd_i && hit(reg_addr_i, ADDR_RELOAD)) begin
      d.rdata = {1'b0, q.reload};
    end else if (reg_rd_i && hit(reg_addr_i, ADDR_CNTHI)) begin
      d.rdata = q.cnt[14:7];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.s1 <= SYNC_RST;
      q.s2 <= SYNC_RST;
      q.s3 <= SYNC_RST;
      q.filt <= SYNC_RST;
      q.sys_rst <= 1'b1;
      q.rc_sel <= 1'b1;
      q.vec <= WAKE_VEC;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign sys_rst_o = q.sys_rst;
  assign clk_sel_rc_o = q.rc_sel;
  assign osc_stop_o = q.osc_stop;
  assign rc_osc_stop_o = q.rc_stop;
  assign ports_float_o = q.ports_float;
  assign cpu_clk_stop_o = q.cpu_stop;
  assign clk_div32_o = q.pwr[PC_SLOW];
  assign wake_irq_o = q.wake_irq;
  assign wake_vector_o = q.vec;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_ovf_reset;
    ovf |=> sys_rst_o && q.cause ##1 !q.run;
  endproperty
  a_ovf_reset: assert property (p_ovf_reset) else $error("overflow did not reset");

  property p_refresh_load;
    refresh && !q.sys_rst |=> q.cnt == {$past(q.reload), 8'h00};
  endproperty
  a_refresh_load: assert property (p_refresh_load) else $error("refresh load wrong");

  property p_halt;
    (q.idle || q.swpd) && !q.sys_rst && !reg_wr_i |=> $stable(q.cnt);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved while halted");

  property p_osc_fail;
    q.osc == OSC_RUN && q.filt[SY_SLOW] && !hwoff_low |=> sys_rst_o && clk_sel_rc_o;
  endproperty
  a_osc_fail: assert property (p_osc_fail) else $error("failure not caught");

  property p_settle_len;
    $rose(q.osc == OSC_RUN) |-> $past(q.settle_cnt) == SETTLE_W'(SETTLE_CYCLES - 1);
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("settle time wrong");

  property p_hw_powerdown_pin;
    hwoff_low |=> sys_rst_o && osc_stop_o && ports_float_o;
  endproperty
  a_hw_powerdown_pin: assert property (p_hw_powerdown_pin) else $error("hw power-down not held");

  property p_idle_entry;
    idle_go && !q.sys_rst |=> cpu_clk_stop_o && q.idle;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

  property p_wake;
    $rose(wake_irq_o) |-> !sys_rst_o && q.osc == OSC_RUN && wake_vector_o == WAKE_VEC ##1 !wake_irq_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up wrong");

  property p_swpd_stop;
    q.osc == OSC_RUN && q.swpd && slow_ok && !hwoff_low |=> osc_stop_o && rc_osc_stop_o;
  endproperty
  a_swpd_stop: assert property (p_swpd_stop) else $error("oscillators not stopped");

  property p_pd_clear;
    $fell(q.swpd) |-> !q.pwr[PC_PD1] && !q.pwr[PC_PD2];
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("mode bits kept");

  property p_run_kept;
    q.run && !q.sys_rst |=> q.run;
  endproperty
  a_run_kept: assert property (p_run_kept) else $error("watchdog stopped while active");

  property p_settle_rst;
    q.osc == OSC_SETTLE && !q.waking |-> sys_rst_o;
  endproperty
  a_settle_rst: assert property (p_settle_rst) else $error("reset released during settling");

  property p_idle_exit;
    q.idle && periph_irq_i |=> !q.idle && !q.pwr[PC_IDLE1] && !q.pwr[PC_IDLE2];
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle not left");

  property p_wake_restart;
    q.osc == OSC_SWPD && !q.filt[SY_INT0] && !hwoff_low |=> !osc_stop_o && !rc_osc_stop_o && !sys_rst_o;
  endproperty
  a_wake_restart: assert property (p_wake_restart) else $error("oscillators not restarted");

endmodule

// File: src/wdps_pkg.sv
// constants and types for the watchdog and power supervisor
package wdps_pkg;
  // register offsets on the byte-wide register port
  localparam logic [3:0] ADDR_PWR = 4'h0;
  localparam logic [3:0] ADDR_WDCTL = 4'h4;
  localparam logic [3:0] ADDR_RELOAD = 4'h8;
  localparam logic [3:0] ADDR_CNTHI = 4'hc;
  // power_control_reg bit positions
  localparam int unsigned PC_IDLE1 = 0;
  localparam int unsigned PC_PD1 = 1;
  localparam int unsigned PC_SLOW = 4;
  localparam int unsigned PC_IDLE2 = 5;
  localparam int unsigned PC_PD2 = 6;
  localparam logic [7:0] PWR_MASK = 8'h73;
  localparam logic [7:0] PWR_RST = 8'h00;
  // watchdog control register bit positions
  localparam int unsigned WC_REFRESH = 0;
  localparam int unsigned WC_START = 1;
  localparam int unsigned WC_CAUSE = 2;
  localparam int unsigned WC_RUN = 3;
  localparam int unsigned WC_RATE = 4;
  // watchdog geometry and prescaler
  localparam int unsigned WDT_W = 15;
  localparam int unsigned RELOAD_W = 7;
  localparam logic [7:0] PRE_FAST_LAST = 8'h05;
  localparam logic [7:0] PRE_SLOW_LAST = 8'hbf;
  localparam logic [4:0] SLOWDOWN_LAST = 5'h1f;
  localparam logic [14:0] WDT_MAX = 15'h7fff;
  // oscillator settling time
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SETTLE_NS = 1000000;
  localparam int unsigned SETTLE_CYC = SETTLE_NS / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W = 20;
  // wake-up interrupt vector
  localparam logic [15:0] WAKE_VEC = 16'h007b;
  // pin synchroniser lanes and their reset levels
  localparam int unsigned SY_SLOW = 0;
  localparam int unsigned SY_HWOFF = 1;
  localparam int unsigned SY_INT0 = 2;
  localparam int unsigned SY_HWST = 3;
  localparam logic [3:0] SYNC_RST = 4'h6;

  typedef enum logic [2:0] {
    OSC_FAIL,
    OSC_SETTLE,
    OSC_RUN,
    OSC_SWPD,
    OSC_HWOFF
  } osc_state_t;
endpackage

// File: tb/watchdog_power_supervisor_tb.sv
// testbench for the watchdog and power supervisor
module watchdog_power_supervisor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import wdps_pkg::*;
  localparam int ST = 20;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic main_osc_slow_i = 1'b0;
  logic hw_powerdown_pin_i = 1'b1;
  logic ext_irq0_wake_pin_i = 1'b1;
  logic wdt_hw_start_pin_i = 1'b0;
  logic periph_irq_i = 1'b0;
  logic sys_rst_o, clk_sel_rc_o, osc_stop_o, rc_osc_stop_o, ports_float_o;
  logic cpu_clk_stop_o, clk_div32_o, wake_irq_o;
  logic [15:0] wake_vector_o;
  int n_fail = 0;
  int n_checks = 0;
  int n;
  logic [7:0] d;

  watchdog_power_supervisor #(.SETTLE_CYCLES(ST)) uut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .main_osc_slow_i(main_osc_slow_i), .hw_powerdown_pin_i(hw_powerdown_pin_i),
    .ext_irq0_wake_pin_i(ext_irq0_wake_pin_i), .wdt_hw_start_pin_i(wdt_hw_start_pin_i),
    .periph_irq_i(periph_irq_i), .sys_rst_o(sys_rst_o), .clk_sel_rc_o(clk_sel_rc_o),
    .osc_stop_o(osc_stop_o), .rc_osc_stop_o(rc_osc_stop_o), .ports_float_o(ports_float_o),
    .cpu_clk_stop_o(cpu_clk_stop_o), .clk_div32_o(clk_div32_o), .wake_irq_o(wake_irq_o),
    .wake_vector_o(wake_vector_o)
  );

  always #5 core_clk_i = ~core_clk_i;

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask

  function automatic logic sel(input int s);
    case (s)
      0: return sys_rst_o;
      1: return wake_irq_o;
      default: return cpu_clk_stop_o;
    endcase
  endfunction

  // polls one output until it reaches a level, counting cycles
  task automatic wait_sig(input int s, input logic v, input int lim, output int k);
    for (k = 0; k < lim && sel(s) !== v; k++) begin
      @(posedge core_clk_i);
      #1;
    end
    if (sel(s) !== v) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, sel(s), v);
      final_report();
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask

  initial begin
    cyc(3);
    chk(sys_rst_o, 1'b1);
    chk(clk_sel_rc_o, 1'b1);
    chk(wake_vector_o, 16'h007b);
    @(posedge core_clk_i);
    nrst_i <= 1'b1;
    wait_sig(0, 1'b0, ST + 20, n);
    chk(n >= ST, 1'b1);
    chk(clk_sel_rc_o, 1'b0);
    rd(ADDR_WDCTL, d);
    chk(d & 8'h04, 8'h00);
    // slow-down on and off
    wr(ADDR_PWR, 8'h10);
    cyc(2);
    chk(clk_div32_o, 1'b1);
    wr(ADDR_PWR, 8'h10 & 8'hef);
    cyc(2);
    chk(clk_div32_o, 1'b0);
    // watchdog start, broken and proper refresh
    wr(ADDR_RELOAD, 8'h7f);
    wr(ADDR_WDCTL, 8'h02);
    rd(ADDR_CNTHI, d);
    chk(d, 8'h00);
    wr(ADDR_WDCTL, 8'h01);
    wr(ADDR_RELOAD, 8'h7f);
    wr(ADDR_WDCTL, 8'h02);
    rd(ADDR_CNTHI, d);
    chk(d, 8'h00);
    wr(ADDR_WDCTL, 8'h01);
    wr(ADDR_WDCTL, 8'h02);
    rd(ADDR_CNTHI, d);
    chk(d, 8'hfe);
    // idle holds the counter, peripheral interrupt ends it
    wr(ADDR_PWR, 8'h01);
    wr(ADDR_PWR, 8'h21);
    cyc(2);
    chk(cpu_clk_stop_o, 1'b1);
    cyc(1000);
    rd(ADDR_CNTHI, d);
    chk(d, 8'hfe);
    @(posedge core_clk_i);
    periph_irq_i <= 1'b1;
    @(posedge core_clk_i);
    periph_irq_i <= 1'b0;
    wait_sig(2, 1'b0, 4, n);
    rd(ADDR_PWR, d);
    chk(d, 8'h00);
    // a plain control write cannot stop it, overflow resets
    wr(ADDR_WDCTL, 8'h00);
    wait_sig(0, 1'b1, 2000, n);
    chk(n > 1500 && n < 1560, 1'b1);
    cyc(3);
    rd(ADDR_WDCTL, d);
    chk(d & 8'h0e, 8'h04);
    // main oscillator failure and recovery
    @(posedge core_clk_i);
    main_osc_slow_i <= 1'b1;
    wait_sig(0, 1'b1, 10, n);
    cyc(2);
    chk(clk_sel_rc_o, 1'b1);
    @(posedge core_clk_i);
    main_osc_slow_i <= 1'b0;
    wait_sig(0, 1'b0, ST + 20, n);
    chk(n >= ST, 1'b1);
    chk(clk_sel_rc_o, 1'b0);
    // software power-down and wake by a short low pulse
    wr(ADDR_PWR, 8'h02);
    wr(ADDR_PWR, 8'h42);
    cyc(2);
    chk({osc_stop_o, rc_osc_stop_o, cpu_clk_stop_o}, 3'b111);
    @(posedge core_clk_i);
    ext_irq0_wake_pin_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    ext_irq0_wake_pin_i <= 1'b1;
    wait_sig(1, 1'b1, ST + 40, n);
    chk(sys_rst_o, 1'b0);
    chk({osc_stop_o, rc_osc_stop_o}, 2'b00);
    cyc(2);
    chk(cpu_clk_stop_o, 1'b0);
    rd(ADDR_PWR, d);
    chk(d, 8'h00);
    // hardware start pin
    @(posedge core_clk_i);
    wdt_hw_start_pin_i <= 1'b1;
    cyc(8);
    rd(ADDR_WDCTL, d);
    chk(d & 8'h0a, 8'h0a);
    // slow rate: one tick per 192 cycles, so a refresh to 7f00 outlives the fast overflow time
    wr(ADDR_RELOAD, 8'h7f);
    wr(ADDR_WDCTL, 8'h11);
    wr(ADDR_WDCTL, 8'h12);
    cyc(19200);
    rd(ADDR_CNTHI, d);
    chk(d, 8'hfe);
    cyc(7680);
    rd(ADDR_CNTHI, d);
    chk(d, 8'hff);
    // hardware power-down replaces state with reset state
    wr(ADDR_PWR, 8'h10);
    @(posedge core_clk_i);
    hw_powerdown_pin_i <= 1'b0;
    wdt_hw_start_pin_i <= 1'b0;
    wait_sig(0, 1'b1, 10, n);
    cyc(2);
    chk({osc_stop_o, ports_float_o, sys_rst_o}, 3'b111);
    cyc(ST);
    chk(sys_rst_o, 1'b1);
    @(posedge core_clk_i);
    hw_powerdown_pin_i <= 1'b1;
    wait_sig(0, 1'b0, ST + 30, n);
    chk(n >= ST, 1'b1);
    chk({ports_float_o, osc_stop_o, clk_div32_o}, 3'b000);
    rd(ADDR_PWR, d);
    chk(d, 8'h00);
    final_report();
  end
endmodule
